/* rtl/buffer_regs_pkg.sv */
// Constants for the byte buffer level and event flag registers
package buffer_regs_pkg;
  localparam logic [6:0] ADDR_CONTROL   = 7'h02;
  localparam logic [6:0] ADDR_THRESHOLD = 7'h03;
  localparam logic [6:0] ADDR_COUNT     = 7'h04;
  localparam logic [6:0] ADDR_DATA      = 7'h05;
  localparam logic [6:0] ADDR_FLAGS0    = 7'h06;
  localparam int PTR_W   = 7;
  localparam int CNT_W   = 10;
  localparam int IDX_W   = 9;
  localparam int MEM_DEPTH = 512;
  localparam logic [9:0] DEPTH_SMALL = 10'h0FF;
  localparam logic [9:0] DEPTH_LARGE = 10'h200;
  // buffer_control field positions
  localparam int CTL_DEPTH_SELECT = 7;
  localparam int CTL_SPACE_ALERT  = 6;
  localparam int CTL_FILL_ALERT   = 5;
  localparam int CTL_EMPTY_CMD    = 4;
  localparam int CTL_THR_MSB      = 2;
  // event_flags_0 field positions
  localparam int FLG_SET_SELECT  = 7;
  localparam int FLG_SPACE_ALERT = 6;
  localparam int FLG_FILL_ALERT  = 5;
  // Values after reset
  localparam logic       RST_DEPTH_SELECT = 1'b0;
  localparam logic [7:0] RST_THRESHOLD    = 8'h00;
  localparam logic [6:0] RST_FLAGS        = 7'h00;
  localparam logic [6:0] RST_POINTER      = 7'h00;
endpackage

/* rtl/byte_store.sv */
// Byte storage array with one write port and one combinational read port
`timescale 1ns/100ps
module byte_store (
  // Clock
  input  wire logic                              clock_i,
  // Write side
  input  wire logic                              wr_en_i,
  input  wire logic [buffer_regs_pkg::IDX_W-1:0] wr_idx_i,
  input  wire logic [7:0]                        wr_data_i,
  // Read side
  input  wire logic [buffer_regs_pkg::IDX_W-1:0] rd_idx_i,
  output logic      [7:0]                        rd_data_o
);
  import buffer_regs_pkg::*;

  logic [7:0] mem [MEM_DEPTH];

  // No reset on the array; contents are only valid below the count
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_idx_i];
endmodule

/* rtl/buffer_level_flags.sv */
// Byte buffer with level, threshold alerts, data port and event_flags_0
//
// Notes on behaviour
// - Control bits 1..0 give count bits 9..8, only in 512-byte mode.
// - Threshold is 8-bit read/write, extended by one control bit in 512-byte mode.
// - Fill alert reads 1 when stored bytes are at or below threshold.
// - Space alert reads 1 when depth minus count is at or below threshold.
// - Depth select 1 means 255 bytes, 0 means 512; change only when empty (not enforced: any control write sets it at any count).
// - Byte count at 04h is read-only, resets to zero, low eight bits.
// - Data port write pushes and counts up; read pops and counts down.
// - Data port access keeps the address pointer; other addresses advance it.
// - Writing 1 to the empty command bit flushes; it always reads 0.
// - Flag write bit 7 picks set or clear for each bit 6..0 written 1.
// - Writing FFh sets all seven flags; writing 7Fh clears all seven, except a flag whose event comes in that same cycle.
// - Flag register at 06h resets to 00h; bit 7 is write-only selector.
// - Flags: command done 4, transmit done 3, receive end 2, error 1, frame 0.
// - Latched space alert at bit 6 sets on live alert rise and stays.
`timescale 1ns/100ps
module buffer_level_flags (
  // Clock and reset
  input  wire logic                              clock_i,
  input  wire logic                              reset_i,
  // Register access from the host interface
  input  wire logic                              addr_load_i,
  input  wire logic [buffer_regs_pkg::PTR_W-1:0] addr_i,
  input  wire logic                              acc_wr_i,
  input  wire logic                              acc_rd_i,
  input  wire logic [7:0]                        wdata_i,
  output logic      [7:0]                        rdata_o,
  output logic                                   rvalid_o,
  output logic      [buffer_regs_pkg::PTR_W-1:0] pointer_o,
  // Event pulses from the core
  input  wire logic                              command_done_i,
  input  wire logic                              transmit_done_i,
  input  wire logic                              receive_end_i,
  input  wire logic                              error_i,
  input  wire logic                              frame_start_i,
  // Status
  output logic      [6:0]                        event_flags_o
);
  import buffer_regs_pkg::*;

  logic [PTR_W-1:0] ptr_q,  ptr_d;
  logic [CNT_W-1:0] cnt_q,  cnt_d;
  logic [IDX_W-1:0] wp_q,   wp_d;
  logic [IDX_W-1:0] rp_q,   rp_d;
  logic             size_q, size_d;
  logic [7:0]       thr_q,  thr_d;
  logic             tmsb_q, tmsb_d;
  logic [6:0]       flg_q,  flg_d;
  logic             sp_prev_q, sp_prev_d;
  logic             fl_prev_q, fl_prev_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             rvalid_q, rvalid_d;

  logic [CNT_W-1:0] depth;
  logic [CNT_W-1:0] thr_eff;
  logic             space_alert;
  logic             fill_alert;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;
  logic             flush;
  logic [7:0]       rd_byte;
  logic [6:0]       hw_set;
  logic [6:0]       sw_set;
  logic [6:0]       sw_clr;

  byte_store u_store (
    .clock_i   (clock_i),
    .wr_en_i   (push),
    .wr_idx_i  (wp_q),
    .wr_data_i (wdata_i),
    .rd_idx_i  (rp_q),
    .rd_data_o (rd_byte)
  );

  always_comb begin
    depth       = size_q ? DEPTH_SMALL : DEPTH_LARGE;
    thr_eff     = size_q ? {2'b00, thr_q} : {1'b0, tmsb_q, thr_q};
    fill_alert  = (cnt_q <= thr_eff);
    space_alert = ((depth - cnt_q) <= thr_eff);
    full        = (cnt_q >= depth);
    empty       = (cnt_q == 10'h000);
    flush       = acc_wr_i && (ptr_q == ADDR_CONTROL) && wdata_i[CTL_EMPTY_CMD];
    // Overflow writes are dropped; popping an empty buffer returns zero
    push        = acc_wr_i && (ptr_q == ADDR_DATA) && !full;
    pop         = acc_rd_i && !acc_wr_i && (ptr_q == ADDR_DATA) && !empty;

    ptr_d = ptr_q;
    if (addr_load_i) begin
      ptr_d = addr_i;
    end else if ((acc_wr_i || acc_rd_i) && (ptr_q != ADDR_DATA)) begin
      ptr_d = ptr_q + 7'h01;
    end

    wp_d  = push ? wp_q + 9'h001 : wp_q;
    rp_d  = pop ? rp_q + 9'h001 : rp_q;
    cnt_d = cnt_q + (push ? 10'h001 : 10'h000) - (pop ? 10'h001 : 10'h000);
    if (flush) begin
      wp_d  = 9'h000;
      rp_d  = 9'h000;
      cnt_d = 10'h000;
    end

    size_d = size_q;
    tmsb_d = tmsb_q;
    thr_d  = thr_q;
    if (acc_wr_i && (ptr_q == ADDR_CONTROL)) begin
      size_d = wdata_i[CTL_DEPTH_SELECT];
      tmsb_d = wdata_i[CTL_THR_MSB];
    end
    if (acc_wr_i && (ptr_q == ADDR_THRESHOLD)) begin
      thr_d = wdata_i;
    end

    // Edge detect on the live alerts; a level would re-set after a clear
    sp_prev_d = space_alert;
    fl_prev_d = fill_alert;
    hw_set    = {space_alert && !sp_prev_q, fill_alert && !fl_prev_q,
                 command_done_i, transmit_done_i, receive_end_i,
                 error_i, frame_start_i};
    sw_set = 7'h00;
    sw_clr = 7'h00;
    if (acc_wr_i && (ptr_q == ADDR_FLAGS0)) begin
      if (wdata_i[FLG_SET_SELECT]) begin
        sw_set = wdata_i[6:0];
      end else begin
        sw_clr = wdata_i[6:0];
      end
    end
    flg_d = ((flg_q & ~sw_clr) | sw_set) | hw_set;

    rvalid_d = acc_rd_i && !acc_wr_i;
    rdata_d  = 8'h00;
    if (acc_rd_i && !acc_wr_i) begin
      case (ptr_q)
        ADDR_CONTROL: begin
          // Count extension reads zero in 255-byte mode
          rdata_d = {size_q, space_alert, fill_alert, 1'b0, 1'b0, tmsb_q,
                     size_q ? 2'b00 : cnt_q[9:8]};
        end
        ADDR_THRESHOLD: begin
          rdata_d = thr_q;
        end
        ADDR_COUNT: begin
          rdata_d = cnt_q[7:0];
        end
        ADDR_DATA: begin
          rdata_d = empty ? 8'h00 : rd_byte;
        end
        ADDR_FLAGS0: begin
          rdata_d = {1'b0, flg_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_q     <= RST_POINTER;
      cnt_q     <= 10'h000;
      wp_q      <= 9'h000;
      rp_q      <= 9'h000;
      size_q    <= RST_DEPTH_SELECT;
      thr_q     <= RST_THRESHOLD;
      tmsb_q    <= 1'b0;
      flg_q     <= RST_FLAGS;
      sp_prev_q <= 1'b0;
      // Live fill alert is 1 after reset; avoids a false latched event
      fl_prev_q <= 1'b1;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
    end else begin
      ptr_q     <= ptr_d;
      cnt_q     <= cnt_d;
      wp_q      <= wp_d;
      rp_q      <= rp_d;
      size_q    <= size_d;
      thr_q     <= thr_d;
      tmsb_q    <= tmsb_d;
      flg_q     <= flg_d;
      sp_prev_q <= sp_prev_d;
      fl_prev_q <= fl_prev_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  assign rdata_o       = rdata_q;
  assign rvalid_o      = rvalid_q;
  assign pointer_o     = ptr_q;
  assign event_flags_o = flg_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence data_access_s;
    (acc_wr_i || acc_rd_i) && !addr_load_i && (ptr_q == ADDR_DATA);
  endsequence
  sequence other_access_s;
    (acc_wr_i || acc_rd_i) && !addr_load_i && (ptr_q != ADDR_DATA);
  endsequence

  AST_PTR_HOLD: assert property (data_access_s |=> $stable(pointer_o))
    else $error("pointer moved on data port access");
  AST_PTR_INC: assert property (other_access_s |=> pointer_o == $past(ptr_q) + 7'h01)
    else $error("pointer did not advance");
  AST_PUSH_CNT: assert property (push && !flush |=> cnt_q == $past(cnt_q) + 10'h001)
    else $error("push did not raise count");
  AST_POP_CNT: assert property (pop |=> cnt_q == $past(cnt_q) - 10'h001)
    else $error("pop did not lower count");
  AST_FLUSH: assert property (flush |=> cnt_q == 10'h000 && wp_q == 9'h000 && rp_q == 9'h000)
    else $error("flush did not empty buffer");
  AST_CTL_READ: assert property (acc_rd_i && !acc_wr_i && ptr_q == ADDR_CONTROL
      |=> rdata_o[CTL_EMPTY_CMD] == 1'b0 && rdata_o[CTL_FILL_ALERT] == $past(fill_alert))
    else $error("control readback wrong");
  AST_EXT_BITS: assert property (acc_rd_i && !acc_wr_i && ptr_q == ADDR_CONTROL && size_q
      |=> rdata_o[1:0] == 2'b00)
    else $error("count extension visible in 255-byte mode");
  AST_SPACE_LATCH: assert property ($rose(space_alert) |-> ##1 flg_q[FLG_SPACE_ALERT]
      ##1 flg_q[FLG_SPACE_ALERT] || $past(sw_clr[FLG_SPACE_ALERT]))
    else $error("space alert not latched");
  AST_SET_WINS: assert property (|(hw_set & sw_clr)
      |=> (flg_q & $past(hw_set) & $past(sw_clr)) == ($past(hw_set) & $past(sw_clr)))
    else $error("clear beat hardware set");
  AST_SW_CLEAR: assert property (sw_clr != 7'h00
      |=> (flg_q & $past(sw_clr) & ~$past(hw_set)) == 7'h00)
    else $error("software clear failed");
  AST_FILL_DEF: assert property (acc_rd_i && !acc_wr_i && ptr_q == ADDR_CONTROL
      && cnt_q == 10'h000 |=> rdata_o[CTL_FILL_ALERT])
    else $error("fill alert clear on empty buffer");
endmodule

/* verification/host_model.sv */
// Host controller model issuing register accesses
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic                              clock_i,
  // Register access
  output logic                                   addr_load_o,
  output logic      [buffer_regs_pkg::PTR_W-1:0] addr_o,
  output logic                                   acc_wr_o,
  output logic                                   acc_rd_o,
  output logic      [7:0]                        wdata_o,
  input  wire logic [7:0]                        rdata_i,
  input  wire logic                              rvalid_i
);
  initial begin
    addr_load_o = 1'b0;
    addr_o      = 7'h00;
    acc_wr_o    = 1'b0;
    acc_rd_o    = 1'b0;
    wdata_o     = 8'h00;
  end
  // Released lines invert so a stale value never passes
  task automatic load(input logic [6:0] a);
    @(posedge clock_i);
    addr_load_o <= 1'b1;
    addr_o      <= a;
    @(posedge clock_i);
    addr_load_o <= 1'b0;
    addr_o      <= ~a;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clock_i);
    acc_wr_o <= 1'b1;
    wdata_o  <= d;
    @(posedge clock_i);
    acc_wr_o <= 1'b0;
    wdata_o  <= ~d;
  endtask
  task automatic rd(output logic [7:0] d, output logic ok);
    @(posedge clock_i);
    acc_rd_o <= 1'b1;
    @(posedge clock_i);
    acc_rd_o <= 1'b0;
    #1;
    d  = rdata_i;
    ok = rvalid_i;
  endtask
endmodule

/* verification/test_buffer_level_flags.sv */
// Self-checking bench for the buffer level and event flag block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_buffer_level_flags;
  import buffer_regs_pkg::*;
  logic       clock_i = 1'b0;
  logic       reset_i = 1'b1;
  logic [4:0] ev_q    = 5'h00;
  logic       ld, wr, rd, rv, ok;
  logic [6:0] addr, ptr, flags, exp;
  logic [7:0] wd, rdat, v;
  int         miscompares = 0;
  int         num_checks  = 0;
  int         cycles      = 0;
  always #10 clock_i = ~clock_i;
  host_model i_host (.clock_i(clock_i), .addr_load_o(ld), .addr_o(addr), .acc_wr_o(wr),
    .acc_rd_o(rd), .wdata_o(wd), .rdata_i(rdat), .rvalid_i(rv));
  buffer_level_flags i_dut (.clock_i(clock_i), .reset_i(reset_i), .addr_load_i(ld),
    .addr_i(addr), .acc_wr_i(wr), .acc_rd_i(rd), .wdata_i(wd), .rdata_o(rdat),
    .rvalid_o(rv), .pointer_o(ptr), .command_done_i(ev_q[4]), .transmit_done_i(ev_q[3]),
    .receive_end_i(ev_q[2]), .error_i(ev_q[1]), .frame_start_i(ev_q[0]),
    .event_flags_o(flags));
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    i_host.load(a);
    i_host.wr(d);
    #1;
  endtask
  task automatic reg_chk(input logic [6:0] a, input logic [7:0] e, input string nm);
    i_host.load(a);
    i_host.rd(v, ok);
    `CHK(nm, {1'b1, e}, {ok, v})
  endtask
  task automatic push(input int n);
    i_host.load(ADDR_DATA);
    for (int i = 0; i < n; i++) i_host.wr(i[7:0]);
  endtask
  task automatic t_reset;
    @(posedge clock_i);
    #1;
    `CHK("flags", 7'h00, flags)
    reg_chk(ADDR_COUNT, 8'h00, "byte_count");
    `CHK("pointer", 7'h05, ptr)
    reg_chk(ADDR_CONTROL, 8'h20, "control");
  endtask
  task automatic t_flags;
    reg_wr(ADDR_FLAGS0, 8'hFF);
    `CHK("flags", 7'h7F, flags)
    reg_wr(ADDR_FLAGS0, 8'h7F);
    `CHK("flags", 7'h00, flags)
    reg_wr(ADDR_FLAGS0, 8'h85);
    `CHK("flags", 7'h05, flags)
    reg_wr(ADDR_FLAGS0, 8'h01);
    `CHK("flags", 7'h04, flags)
    reg_chk(ADDR_FLAGS0, 8'h04, "event_flags_0");
    exp = 7'h04;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i);
      ev_q <= 5'h01 << i;
      @(posedge clock_i);
      ev_q <= 5'h00;
      #1;
      exp = exp | (7'h01 << i);
      `CHK("event flag", exp, flags)
    end
    // Event and clear land on the same edge
    i_host.load(ADDR_FLAGS0);
    fork
      i_host.wr(8'h7F);
      begin
        @(posedge clock_i);
        ev_q <= 5'h10;
        @(posedge clock_i);
        ev_q <= 5'h00;
      end
    join
    #1;
    `CHK("flags", 7'h10, flags)
  endtask
  task automatic t_data;
    i_host.load(ADDR_DATA);
    i_host.wr(8'hA1);
    i_host.wr(8'hB2);
    i_host.wr(8'hC3);
    #1;
    `CHK("pointer", 7'h05, ptr)
    reg_chk(ADDR_COUNT, 8'h03, "byte_count");
    reg_chk(ADDR_DATA, 8'hA1, "data");
    i_host.rd(v, ok);
    `CHK("data", {1'b1, 8'hB2}, {ok, v})
    i_host.rd(v, ok);
    `CHK("data", {1'b1, 8'hC3}, {ok, v})
    reg_chk(ADDR_COUNT, 8'h00, "byte_count");
  endtask
  task automatic t_levels;
    reg_wr(ADDR_CONTROL, 8'h04);
    push(256);
    reg_chk(ADDR_CONTROL, 8'h65, "control");
    reg_chk(ADDR_COUNT, 8'h00, "byte_count");
    `CHK("space latched", 1'b1, flags[6])
    reg_wr(ADDR_CONTROL, 8'h10);
    reg_chk(ADDR_CONTROL, 8'h20, "control");
    `CHK("space latched", 1'b1, flags[6])
    reg_wr(ADDR_CONTROL, 8'h80);
    reg_wr(ADDR_THRESHOLD, 8'h01);
    reg_chk(ADDR_THRESHOLD, 8'h01, "threshold");
    reg_wr(ADDR_FLAGS0, 8'h7F);
    push(254);
    reg_chk(ADDR_CONTROL, 8'hC0, "control");
    `CHK("space latched", 1'b1, flags[6])
    push(2);
    reg_chk(ADDR_COUNT, 8'hFF, "byte_count");
    reg_chk(ADDR_CONTROL, 8'hC0, "control");
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the roughly 1150 cycles the run needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset();
    t_flags();
    t_data();
    t_levels();
    results();
  end
endmodule
